/* rtl/adcs_pkg.sv */
// Package for the converter sequencer control block.
// Assumes a 32-bit Avalon-MM slave with byte addresses equal to four times
// the register index.
package adcs_pkg;
	// ----------------------------------------------------------------
	// Register indexes (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_RESULT_HI = 8'hE0;
	localparam logic [7:0] IDX_RESULT_LO = 8'hE1;
	localparam logic [7:0] IDX_CSR = 8'hE8;
	localparam logic [7:0] IDX_TRIG = 8'hE9;
	localparam logic [7:0] IDX_INT_STAT = 8'hF0;
	localparam logic [7:0] IDX_INT_CLR = 8'hF1;
	localparam logic [7:0] IDX_INT_EN = 8'hF2;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int RES_W = 10;
	localparam int RES_PAD = 6;
	localparam int TRIG_EN_BIT = 7;
	localparam logic [7:0] TRIG_FIXED = 8'h7E;
	localparam logic [7:0] CSR_RESET = 8'h00;
	localparam int EV_W = 2;
	localparam int EV_DONE = 0;
	localparam int EV_TRIG = 1;

	// ----------------------------------------------------------------
	// Conversion time, in system states
	// ----------------------------------------------------------------
	localparam logic [8:0] CONV_SLOW = 9'h10A;
	localparam logic [8:0] CONV_FAST = 9'h086;
	localparam logic [8:0] CNT_ONE = 9'h001;
	localparam logic [8:0] CNT_ZERO = 9'h000;

	// Control and status register, bit 7 down to bit 0
	typedef struct packed {
		logic conversion_done_flag;
		logic irq_en;
		logic conversion_go;
		logic scan_mode;
		logic clk_fast;
		logic input_group_select;
		logic input_select_high;
		logic input_select_low;
	} adcs_csr_t;

	typedef enum logic {
		ADCS_IDLE,
		ADCS_CONV
	} adcs_state_t;
endpackage

/* rtl/adcs_top.sv */
// Converter sequencer control: registers, start logic, scan sequencing.
// Assumes an Avalon-MM master on core_clk, and an analog front end that
// holds ana_data stable by the end of each conversion window.
`timescale 1ns/1ps
module adcs_top (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic external_trigger_input,
	input wire logic standby_req,
	input wire logic [9:0] ana_data,
	output logic [2:0] ana_chan,
	output logic ana_sample,
	output logic irq
);
	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	// Last input of a scan pass, or the single input, from the channel field
	function automatic logic [2:0] last_chan(input adcs_pkg::adcs_csr_t c);
		last_chan = {c.input_group_select, c.input_select_high, c.input_select_low};
	endfunction

	// First input of the selected group
	function automatic logic [2:0] first_chan(input adcs_pkg::adcs_csr_t c);
		first_chan = {c.input_group_select, 2'b00};
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	// Register and sequencer state
	adcs_pkg::adcs_csr_t csr_r;
	adcs_pkg::adcs_csr_t csr_nxt;
	adcs_pkg::adcs_state_t state_r;
	adcs_pkg::adcs_state_t state_nxt;
	logic trig_en_r;
	logic [adcs_pkg::RES_W-1:0] res_r;
	logic [8:0] cnt_r;
	logic [8:0] cnt_nxt;
	logic [2:0] chan_r;
	logic [2:0] chan_nxt;

	// Bus side and interrupt state
	logic armed_r;
	logic [adcs_pkg::EV_W-1:0] ist_r;
	logic [adcs_pkg::EV_W-1:0] ien_r;
	logic wait_r;
	logic [31:0] rdata_r;
	logic irq_r;

	// Front end and synchroniser stages
	logic sample_r;
	logic trg_s1_r;
	logic trg_s2_r;
	logic trg_s3_r;
	logic [9:0] dat_s1_r;
	logic [9:0] dat_s2_r;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire [7:0] idx = avs_address[9:2];
	wire req = avs_read | avs_write;
	wire wr_acc = avs_write & ~wait_r & avs_byteenable[0];
	wire rd_acc = avs_read & ~wait_r;
	wire wr_csr = wr_acc & (idx == adcs_pkg::IDX_CSR);
	wire wr_trig = wr_acc & (idx == adcs_pkg::IDX_TRIG);
	wire wr_iclr = wr_acc & (idx == adcs_pkg::IDX_INT_CLR);
	wire wr_ien = wr_acc & (idx == adcs_pkg::IDX_INT_EN);
	wire rd_csr = rd_acc & (idx == adcs_pkg::IDX_CSR);
	wire [7:0] wbyte = avs_writedata[7:0];
	wire adcs_pkg::adcs_csr_t wcsr = adcs_pkg::adcs_csr_t'(wbyte);
	// Flag as the master sees it in the csr read now being answered
	wire adcs_pkg::adcs_csr_t rd_seen = adcs_pkg::adcs_csr_t'(rdata_r[7:0]);

	// Read mux; reserved trigger bits read one, bit 0 reads zero
	wire [15:0] res_word = {res_r, {adcs_pkg::RES_PAD{1'b0}}};
	wire [7:0] trig_rd = adcs_pkg::TRIG_FIXED | {trig_en_r, 7'h00};
	wire [31:0] rd_mux =
		(idx == adcs_pkg::IDX_RESULT_HI) ? {16'h0000, res_word} :
		(idx == adcs_pkg::IDX_RESULT_LO) ? {24'h000000, res_word[7:0]} :
		(idx == adcs_pkg::IDX_CSR) ? {24'h000000, csr_r} :
		(idx == adcs_pkg::IDX_TRIG) ? {24'h000000, trig_rd} :
		(idx == adcs_pkg::IDX_INT_STAT) ? {30'h00000000, ist_r} :
		(idx == adcs_pkg::IDX_INT_EN) ? {30'h00000000, ien_r} :
		32'h00000000;

	// ----------------------------------------------------------------
	// Start and sequencing conditions
	// ----------------------------------------------------------------
	// Falling edge seen on synchronised stages only
	wire trg_fall = trg_s3_r & ~trg_s2_r;
	wire ext_start = trg_fall & trig_en_r;
	wire [8:0] conv_len = csr_r.clk_fast ? adcs_pkg::CONV_FAST : adcs_pkg::CONV_SLOW;
	wire conv_end = (state_r == adcs_pkg::ADCS_CONV) & (cnt_r == conv_len - adcs_pkg::CNT_ONE);
	wire pass_end = conv_end & (~csr_r.scan_mode | chan_r == last_chan(csr_r));
	wire go_sw_set = wr_csr & wcsr.conversion_go & ~csr_r.conversion_go;
	// A trigger edge only counts as taken while the converter is stopped
	wire ext_taken = ext_start & ~csr_r.conversion_go & ~standby_req;
	wire start_ev = go_sw_set | ext_taken;
	// Flag clear needs a prior read that saw it set; a set in the same cycle wins
	wire flag_clr = wr_csr & ~wcsr.conversion_done_flag & armed_r;

	// ----------------------------------------------------------------
	// Next control/status value
	// ----------------------------------------------------------------
	always_comb begin
		csr_nxt = csr_r;
		if (wr_csr) begin
			csr_nxt = wcsr;
			csr_nxt.conversion_done_flag = csr_r.conversion_done_flag;
		end
		if (ext_start) begin
			csr_nxt.conversion_go = 1'b1;
		end
		if (conv_end & ~csr_r.scan_mode & ~go_sw_set) begin
			csr_nxt.conversion_go = 1'b0;
		end
		if (standby_req) begin
			csr_nxt.conversion_go = 1'b0;
		end
		if (flag_clr) begin
			csr_nxt.conversion_done_flag = 1'b0;
		end
		if (pass_end) begin
			csr_nxt.conversion_done_flag = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Conversion sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		chan_nxt = chan_r;
		unique case (state_r)
			adcs_pkg::ADCS_IDLE: begin
				cnt_nxt = adcs_pkg::CNT_ZERO;
				if (start_ev & ~standby_req) begin
					state_nxt = adcs_pkg::ADCS_CONV;
					chan_nxt = csr_nxt.scan_mode ? first_chan(csr_nxt) : last_chan(csr_nxt);
				end
			end
			adcs_pkg::ADCS_CONV: begin
				cnt_nxt = cnt_r + adcs_pkg::CNT_ONE;
				if (conv_end) begin
					cnt_nxt = adcs_pkg::CNT_ZERO;
					if (!csr_r.scan_mode) begin
						state_nxt = adcs_pkg::ADCS_IDLE;
					end else if (pass_end) begin
						chan_nxt = first_chan(csr_r);
					end else begin
						chan_nxt = chan_r + 3'h1;
					end
				end
			end
		endcase
		// Go at zero forces idle, whatever the sequencer was doing
		if (!csr_nxt.conversion_go) begin
			state_nxt = adcs_pkg::ADCS_IDLE;
			cnt_nxt = adcs_pkg::CNT_ZERO;
		end
	end

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	// Analog data is only taken at the end of a window, when it is stable
	// Per-bit sync of the word is safe only because the front end holds it still
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			trg_s1_r <= 1'b1;
			trg_s2_r <= 1'b1;
			trg_s3_r <= 1'b1;
			dat_s1_r <= 10'h000;
			dat_s2_r <= 10'h000;
		end else begin
			trg_s1_r <= external_trigger_input;
			trg_s2_r <= trg_s1_r;
			trg_s3_r <= trg_s2_r;
			dat_s1_r <= ana_data;
			dat_s2_r <= dat_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			csr_r <= adcs_pkg::adcs_csr_t'(adcs_pkg::CSR_RESET);
			trig_en_r <= 1'b0;
			state_r <= adcs_pkg::ADCS_IDLE;
			cnt_r <= adcs_pkg::CNT_ZERO;
			chan_r <= 3'h0;
		end else begin
			csr_r <= csr_nxt;
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			chan_r <= chan_nxt;
			if (wr_trig) begin
				trig_en_r <= wbyte[adcs_pkg::TRIG_EN_BIT];
			end
		end
	end

	// Result capture at the end of each conversion
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			res_r <= 10'h000;
		end else if (conv_end) begin
			res_r <= dat_s2_r;
		end
	end

	// Read of a set flag arms the clear; any other csr access disarms it
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			armed_r <= 1'b0;
		end else if (rd_csr) begin
			armed_r <= rd_seen.conversion_done_flag;
		end else if (wr_csr) begin
			armed_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status, enable and output
	// ----------------------------------------------------------------
	// Events: bit 0 scan or single pass done, bit 1 external start taken
	wire [adcs_pkg::EV_W-1:0] ev = {ext_taken, pass_end};
	wire [adcs_pkg::EV_W-1:0] iclr = wr_iclr ? wbyte[adcs_pkg::EV_W-1:0] : 2'b00;
	// An event in the same cycle as its clear wins, so none is lost
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ist_r <= 2'b00;
			ien_r <= 2'b00;
			irq_r <= 1'b0;
		end else begin
			ist_r <= (ist_r & ~iclr) | ev;
			if (wr_ien) begin
				ien_r <= wbyte[adcs_pkg::EV_W-1:0];
			end
			irq_r <= (csr_nxt.conversion_done_flag & csr_nxt.irq_en) | (|(ist_r & ien_r));
		end
	end

	// ----------------------------------------------------------------
	// Bus answer: one wait cycle, then waitrequest low for one cycle
	// ----------------------------------------------------------------
	// A fixed wait cycle registers the read mux, at the cost of half the bus rate
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wait_r <= 1'b1;
			rdata_r <= 32'h00000000;
		end else begin
			wait_r <= ~(req & wait_r);
			if (req & wait_r) begin
				rdata_r <= avs_read ? rd_mux : 32'h00000000;
			end
		end
	end

	// ----------------------------------------------------------------
	// Front end controls
	// ----------------------------------------------------------------
	// Sample pulse marks the first cycle of every conversion window
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sample_r <= 1'b0;
		end else begin
			sample_r <= (state_nxt == adcs_pkg::ADCS_CONV) & (cnt_nxt == adcs_pkg::CNT_ZERO);
		end
	end

	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;
	assign ana_chan = chan_r;
	assign ana_sample = sample_r;
	assign irq = irq_r;
endmodule

/* tb/adcs_monitor.sv */
// Checker bound to adcs_top: bus answer, window start, input pick, irq gating
// Assumes the bench writes go only while the converter is idle
`timescale 1ns/1ps
module adcs_monitor (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [2:0] ana_chan,
	input wire logic ana_sample,
	input wire logic irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	logic [7:0] csr_r;
	logic ien_r;
	wire wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
	wire csr_wr = wr_ok && avs_address[9:2] == adcs_pkg::IDX_CSR;
	// Mirror of written fields; go and done go stale here, so only fields are trusted
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			csr_r <= 8'h00;
			ien_r <= 1'h0;
		end else begin
			if (csr_wr) csr_r <= avs_writedata[7:0];
			if (wr_ok && avs_address[9:2] == adcs_pkg::IDX_INT_EN) ien_r <= |avs_writedata[1:0];
		end
	end
	sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
	sequence s_ans; !avs_waitrequest ##1 avs_waitrequest; endsequence
	// Bus: one wait cycle, a one-cycle answer, read data moves only with it
	a_bus_answer: assert property (s_req |=> s_ans) else $error("bus answer");
	a_bus_idle: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
		else $error("answer without request");
	a_data_held: assert property ($changed(avs_readdata) |-> !avs_waitrequest)
		else $error("read data moved");
	// Windows: started by go, one strobe, input taken from the fields
	a_go_start: assert property (csr_wr && avs_writedata[5] && !csr_r[5] |=> ana_sample)
		else $error("go start");
	a_sample_pulse: assert property (ana_sample |=> !ana_sample) else $error("sample strobe");
	a_group_pick: assert property (ana_sample |-> ana_chan[2] == csr_r[2])
		else $error("input group");
	a_input_pick: assert property (ana_sample |-> (csr_r[4] ? ana_chan[1:0] <= csr_r[1:0]
		: ana_chan[1:0] == csr_r[1:0])) else $error("input pick");
	// Done-flag path uses the enable as just written, status path the one before
	a_irq_gate: assert property (irq |-> csr_r[6] || $past(ien_r)) else $error("irq gate");
endmodule

/* tb/adcs_front.sv */
// Model of the analog input mux and the external trigger pin
// Assumes the bench asks for a trigger with a one-cycle command
`timescale 1ns/1ps
module adcs_front (
	input wire logic core_clk,
	input wire logic [2:0] ana_chan,
	input wire logic [6:0] level,
	input wire logic trig_fall,
	output logic [9:0] ana_data,
	output logic external_trigger_input
);
	logic [2:0] low_r = 3'h0;
	// Each input shows its own number in the top bits, so a wrong pick is visible
	assign ana_data = {ana_chan, level};
	// Pin idles high on its pull-up and is pulled low four cycles per command
	always @(posedge core_clk) begin
		if (trig_fall) low_r <= 3'h4;
		else if (low_r != 3'h0) low_r <= low_r - 3'h1;
	end
	assign external_trigger_input = (low_r == 3'h0);
endmodule

/* tb/tb_adc_sequencer_control.sv */
// Bench for adcs_top: random single and scan runs, trigger starts, standby
// Assumes adcs_front on the analog side and adcs_monitor bound below
`timescale 1ns/1ps
module tb_adc_sequencer_control;
	logic core_clk, avs_waitrequest, ana_sample, irq, ext_pin;
	logic nrst = 1'h0, avs_read = 1'h0, avs_write = 1'h0, standby_req = 1'h0, trig_fall = 1'h0;
	logic [9:0] avs_address = 10'h000, ana_data;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, r;
	logic [3:0] avs_byteenable = 4'hF;
	logic [6:0] level = 7'h00;
	logic [7:0] v, e;
	logic [2:0] ana_chan;
	int errors, check_count, cyc, samples, n, seed = 32'hAAF6;
	adcs_top i_dut (.core_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .external_trigger_input(ext_pin),
		.standby_req, .ana_data, .ana_chan, .ana_sample, .irq);
	adcs_front i_front (.core_clk, .ana_chan, .level, .trig_fall, .ana_data,
		.external_trigger_input(ext_pin));
	initial begin
		core_clk = 1'h0;
		forever #10 core_clk = ~core_clk;
	end
	// Hang limit, and a tally of windows seen at the sample strobe
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (ana_sample === 1'h1) samples <= samples + 1;
		if (cyc == 30000) begin
			errors++;
			end_of_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Master raises after an edge and holds until waitrequest is seen low
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		@(posedge core_clk);
		avs_address <= {idx, 2'h0};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {24'h0, wd};
		do @(posedge core_clk);
		while (avs_waitrequest !== 1'h0);
		rd = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
	endtask
	task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
		bus(1'h0, idx, 8'h00);
		chk(rd, exp);
	endtask
	task automatic pulse();
		trig_fall <= 1'h1;
		@(posedge core_clk);
		trig_fall <= 1'h0;
	endtask
	// A stopped converter must not open a single window in 300 cycles
	task automatic quiet();
		repeat (300) @(posedge core_clk);
		chk(samples, n);
	endtask
	// Nominal time a start takes to raise the flag, from the speed, scan and channel fields
	function automatic int win_len(input logic [7:0] cv);
		win_len = (cv[3] ? 134 : 266) * (cv[4] ? int'(cv[1:0]) + 1 : 1);
	endfunction
	// Result word of the last input, as the front model presents it
	function automatic logic [31:0] res_hi(input logic [2:0] ch, input logic [6:0] lv);
		res_hi = {16'h0, ch, lv, 6'h00};
	endfunction
	// Start by write or pin, poll the done flag, then check time and result
	task automatic conv(input logic pin, input logic [7:0] cv, input logic [2:0] last);
		int t0;
		int win;
		win = win_len(cv);
		bus(1'h1, adcs_pkg::IDX_CSR, cv);
		if (pin) pulse();
		t0 = cyc;
		do bus(1'h0, adcs_pkg::IDX_CSR, 8'h00);
		while (rd[7] !== 1'h1 && cyc - t0 < 1500);
		chk(32'(cyc - t0 >= win - 2 && cyc - t0 <= win + 12), 32'h1);
		rdchk(adcs_pkg::IDX_RESULT_HI, res_hi(last, level));
		rdchk(adcs_pkg::IDX_RESULT_LO, {24'h0, level[1:0], 6'h00});
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		nrst <= 1'h1;
		// Reset values, fixed trigger bits, an unmapped place
		rdchk(adcs_pkg::IDX_RESULT_HI, 32'h0);
		rdchk(adcs_pkg::IDX_CSR, 32'h0);
		rdchk(adcs_pkg::IDX_TRIG, 32'h7E);
		rdchk(8'h10, 32'h0);
		// Single runs on every input; writing 1 to the flag must not clear it
		for (int i = 0; i < 8; i++) begin
			r = $random(seed);
			level <= r[14:8];
			v = {1'h0, r[0], 2'h2, r[1], i[2:0]};
			e = {1'h1, r[0], 2'h0, r[1], i[2:0]};
			conv(1'h0, v, i[2:0]);
			rdchk(adcs_pkg::IDX_CSR, {24'h0, e});
			chk({31'h0, irq}, {31'h0, r[0]});
			bus(1'h1, adcs_pkg::IDX_CSR, e);
			rdchk(adcs_pkg::IDX_CSR, {24'h0, e});
			bus(1'h1, adcs_pkg::IDX_CSR, e & 8'h7F);
			rdchk(adcs_pkg::IDX_CSR, {24'h0, e & 8'h7F});
			chk({31'h0, irq}, 32'h0);
		end
		// Scan passes over random groups, then go cleared
		for (int i = 0; i < 3; i++) begin
			r = $random(seed);
			conv(1'h0, {4'h3, r[3:0]}, r[2:0]);
			bus(1'h1, adcs_pkg::IDX_CSR, {4'h1, r[3:0]});
			n = samples;
			quiet();
		end
		// Pin start with its own interrupt; then pin and masked write ignored
		bus(1'h1, adcs_pkg::IDX_INT_EN, 8'h02);
		rdchk(adcs_pkg::IDX_INT_EN, 32'h2);
		bus(1'h1, adcs_pkg::IDX_TRIG, 8'h80);
		rdchk(adcs_pkg::IDX_TRIG, 32'hFE);
		conv(1'h1, 8'h05, 3'h5);
		bus(1'h1, adcs_pkg::IDX_CSR, 8'h00);
		rdchk(adcs_pkg::IDX_INT_STAT, 32'h3);
		chk({31'h0, irq}, 32'h1);
		bus(1'h1, adcs_pkg::IDX_INT_CLR, 8'h03);
		rdchk(adcs_pkg::IDX_INT_STAT, 32'h0);
		chk({31'h0, irq}, 32'h0);
		bus(1'h1, adcs_pkg::IDX_TRIG, 8'h00);
		n = samples;
		pulse();
		avs_byteenable <= 4'h0;
		bus(1'h1, adcs_pkg::IDX_CSR, 8'h20);
		avs_byteenable <= 4'hF;
		quiet();
		// Standby drops go in mid scan
		bus(1'h1, adcs_pkg::IDX_CSR, 8'h33);
		standby_req <= 1'h1;
		rdchk(adcs_pkg::IDX_CSR, 32'h13);
		n = samples;
		quiet();
		// Reset in mid scan stops it and restores the csr, result high and trigger registers
		standby_req <= 1'h0;
		bus(1'h1, adcs_pkg::IDX_CSR, 8'h33);
		repeat (20) @(posedge core_clk);
		chk(32'(samples > n), 32'h1);
		nrst <= 1'h0;
		repeat (2) @(posedge core_clk);
		nrst <= 1'h1;
		rdchk(adcs_pkg::IDX_CSR, 32'h0);
		rdchk(adcs_pkg::IDX_RESULT_HI, 32'h0);
		rdchk(adcs_pkg::IDX_TRIG, 32'h7E);
		n = samples;
		quiet();
		end_of_test();
	end
endmodule
bind adcs_top adcs_monitor i_mon (.core_clk, .nrst, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .ana_chan,
	.ana_sample, .irq);
